// [pmc_map.svh]
// Offsets, field positions, reset values and timing counts of the module control pins.
// Functional notes
// - Serial bus answered only while selected.
// - Host drives separate select line per module.
// - Long reset low restores all default settings.
// - Host ignores status until reset completes.
// - Reset done: attention with init-pending clear.
// - Power-up raises same completion attention.
// - Fully functional within 2000 ms.
// - Power limit select caps module power.
// - Inserted module pulls presence line low.
// - Attention low flags fault or status.
// - Host reads module to find source.
// - Attention open drain, host pulls up.
// - Lanes individually addressable, unused switched off.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_CLK_NS       25
`define PMC_CLK_KHZ      40000
`define PMC_INIT_MS      2000
`define PMC_INIT_CYC     (`PMC_INIT_MS * `PMC_CLK_KHZ)
`define PMC_RST_MIN_NS   10000
`define PMC_RST_MIN_CYC  ((`PMC_RST_MIN_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_SCL_HALF     4'h4
`define PMC_SLOT_LAST    5'h10
`define PMC_SLOT_DATA    5'h09
`define PMC_SLOT_ADDR    5'h08
`define PMC_DEV_STATUS   7'h00
`define PMC_DEV_LANES    7'h01
`define PMC_ST_PEND      0
`define PMC_ST_FAULT     1
`define PMC_ST_READY     2
`define PMC_HOST_CTRL    2'h0
`define PMC_HOST_TXN     2'h1
`define PMC_HOST_STATUS  2'h2
`define PMC_CTRL_SEL     0
`define PMC_CTRL_RESTART 1
`define PMC_CTRL_LOWPWR  2
`define PMC_CTRL_RESET   3'h4
`define PMC_HS_BUSY      0
`define PMC_HS_ATTN      1
`define PMC_HS_PRESENT   2
`endif

// [pmc_pkg.sv]
// Types shared by both ends of the module control pins.
package pmc_pkg;
  typedef enum logic [0:0] {
    PMC_H_IDLE = 1'b0,
    PMC_H_RUN  = 1'b1
  } pmc_host_st_t;
  typedef enum logic [0:0] {
    PMC_D_IDLE  = 1'b0,
    PMC_D_FRAME = 1'b1
  } pmc_dev_st_t;
endpackage

// [pmc_if.sv]
// Low-speed pins between host controller and module, with wire resolution.
interface pmc_if;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;
  logic module_select_n;
  logic hard_restart_n;
  logic power_limit_select;
  logic att_o;
  logic att_oe;
  logic attention_n;
  logic pres_o;
  logic pres_oe;
  logic presence_detect_n;
  // Pull-ups on the host board; any enabled low driver wins.
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
  assign attention_n = !(att_oe && !att_o);
  assign presence_detect_n = !(pres_oe && !pres_o);
  modport dev_mp (
    input  scl,
    input  sda,
    output sda_d_o,
    output sda_d_oe,
    input  module_select_n,
    input  hard_restart_n,
    input  power_limit_select,
    output att_o,
    output att_oe,
    output pres_o,
    output pres_oe
  );
  modport host_mp (
    output scl,
    input  sda,
    output sda_h_o,
    output sda_h_oe,
    output module_select_n,
    output hard_restart_n,
    output power_limit_select,
    input  attention_n,
    input  presence_detect_n
  );
endinterface

// [pmc_host.sv]
// Host controller end: command registers, serial master and pin drivers.
`include "pmc_map.svh"
module pmc_host
  import pmc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [1:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  pmc_if.host_mp           LINK
);
  pmc_host_st_t st_q;
  logic [2:0]   ctrl_q;
  logic [4:0]   slot_q;
  logic [3:0]   div_q;
  logic         scl_q;
  logic         oe_q;
  logic         rw_q;
  logic [16:0]  frame_q;
  logic [7:0]   rd_q;
  logic [15:0]  rdata_q;
  logic         att_s1_q, att_s2_q;
  logic         prs_s1_q, prs_s2_q;
  logic         sda_s1_q, sda_s2_q;
  logic         tick;
  logic         start;

  assign tick  = (div_q == `PMC_SCL_HALF - 4'h1);
  assign start = WR && (ADDR == `PMC_HOST_TXN) && (st_q == PMC_H_IDLE);

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      att_s1_q <= 1'b0;
      att_s2_q <= 1'b0;
      prs_s1_q <= 1'b0;
      prs_s2_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end
    else
    begin
      att_s1_q <= !LINK.attention_n;
      att_s2_q <= att_s1_q;
      prs_s1_q <= !LINK.presence_detect_n;
      prs_s2_q <= prs_s1_q;
      sda_s1_q <= LINK.sda;
      sda_s2_q <= sda_s1_q;
    end

  // Power limit starts set, so an unknown module comes up in its low class.
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      ctrl_q <= `PMC_CTRL_RESET;
    else if (WR && ADDR == `PMC_HOST_CTRL)
      ctrl_q <= WDATA[2:0];

  // Serial master: the link clock is divided down from CLK and driven out.
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      st_q    <= PMC_H_IDLE;
      slot_q  <= 5'h00;
      div_q   <= 4'h0;
      scl_q   <= 1'b1;
      oe_q    <= 1'b0;
      rw_q    <= 1'b0;
      frame_q <= 17'h0_0000;
      rd_q    <= 8'h00;
    end
    else
      case (st_q)
        PMC_H_IDLE:
          if (start)
          begin
            st_q    <= PMC_H_RUN;
            frame_q <= {1'b0, WDATA[7:0], WDATA[15:8]};
            rw_q    <= WDATA[7];
            oe_q    <= 1'b1;
            scl_q   <= 1'b0;
            slot_q  <= 5'h00;
            div_q   <= 4'h0;
          end
          // Data lets go one clock after the last rising edge, so it never moves under it.
          else
            oe_q <= 1'b0;
        PMC_H_RUN:
          if (!tick)
            div_q <= div_q + 4'h1;
          else
          begin
            div_q <= 4'h0;
            if (!scl_q)
            begin
              scl_q <= 1'b1;
              if (rw_q && slot_q >= `PMC_SLOT_DATA)
                rd_q <= {rd_q[6:0], sda_s2_q};
              if (slot_q == `PMC_SLOT_LAST)
                st_q <= PMC_H_IDLE;
            end
            else
            begin
              scl_q   <= 1'b0;
              slot_q  <= slot_q + 5'h01;
              frame_q <= {frame_q[15:0], 1'b0};
              oe_q    <= !frame_q[15] && !(rw_q && slot_q >= `PMC_SLOT_ADDR);
            end
          end
        default:
          st_q <= PMC_H_IDLE;
      endcase

  // Software polls attention and reads module status.
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      rdata_q <= 16'h0000;
    else if (!RD)
      rdata_q <= 16'h0000;
    else
      case (ADDR)
        `PMC_HOST_CTRL:
          rdata_q <= {13'h0000, ctrl_q};
        `PMC_HOST_STATUS:
          rdata_q <= {rd_q, 5'h00, prs_s2_q, att_s2_q, st_q == PMC_H_RUN};
        default:
          rdata_q <= 16'h0000;
      endcase

  assign RDATA = rdata_q;
  assign LINK.scl = scl_q;
  assign LINK.sda_h_o = 1'b0;
  assign LINK.sda_h_oe = oe_q;
  assign LINK.module_select_n = !ctrl_q[`PMC_CTRL_SEL];
  // Hard restart held low by software.
  assign LINK.hard_restart_n = !ctrl_q[`PMC_CTRL_RESTART];
  assign LINK.power_limit_select = ctrl_q[`PMC_CTRL_LOWPWR];
endmodule

// [pmc_device.sv]
// Module end: reset filter, initialisation timer, attention and serial slave.
`include "pmc_map.svh"
module pmc_device
  import pmc_pkg::*;
#(
  parameter int unsigned INIT_CYC    = `PMC_INIT_CYC,
  parameter int unsigned RST_MIN_CYC = `PMC_RST_MIN_CYC
)
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  pmc_if.dev_mp           LINK,
  input  wire logic       FAULT,
  output logic      [3:0] LANE_OFF,
  output logic            POWER_LOW,
  output logic            INIT_PENDING
);
  logic         rst_s1_q, rst_s2_q;
  logic         pls_s1_q, pls_s2_q;
  logic [31:0]  rst_cnt_q;
  logic         mod_rst_q;
  logic         link_rst_n_q;
  logic [31:0]  init_cnt_q;
  logic         pend_q;
  logic         ready_q;
  logic         att_q;
  logic         clr_s1_q, clr_s2_q, clr_s3_q;
  logic         ready_clr;
  logic         ready_set;
  logic         pend_l1_q, pend_l2_q;
  logic         flt_l1_q, flt_l2_q;
  logic         rdy_l1_q, rdy_l2_q;
  pmc_dev_st_t  st_q;
  logic [4:0]   cnt_q;
  logic         rw_q;
  logic [6:0]   addr_q;
  logic [7:0]   sh_q;
  logic         oe_q;
  logic [3:0]   lane_q;
  logic         clr_tgl_q;
  logic [6:0]   addr_next;
  logic [7:0]   rd_byte;

  // The restart and power limit pins from the host pass two flip-flops before any logic sees them.
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      pls_s1_q <= 1'b1;
      pls_s2_q <= 1'b1;
    end
    else
    begin
      rst_s1_q <= LINK.hard_restart_n;
      rst_s2_q <= rst_s1_q;
      pls_s1_q <= LINK.power_limit_select;
      pls_s2_q <= pls_s1_q;
    end

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      rst_cnt_q <= 32'h0000_0000;
    else if (rst_s2_q)
      rst_cnt_q <= 32'h0000_0000;
    else if (rst_cnt_q != RST_MIN_CYC)
      rst_cnt_q <= rst_cnt_q + 32'h0000_0001;

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      mod_rst_q    <= 1'b1;
      link_rst_n_q <= 1'b0;
    end
    else
    begin
      mod_rst_q    <= !rst_s2_q && (rst_cnt_q == RST_MIN_CYC);
      link_rst_n_q <= !(!rst_s2_q && (rst_cnt_q == RST_MIN_CYC));
    end

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      init_cnt_q <= 32'h0000_0000;
    else if (mod_rst_q)
      init_cnt_q <= 32'h0000_0000;
    else if (init_cnt_q != INIT_CYC)
      init_cnt_q <= init_cnt_q + 32'h0000_0001;

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      pend_q <= 1'b1;
    else
      pend_q <= mod_rst_q || (init_cnt_q != INIT_CYC);

  // A read of the status byte on the link toggles; the second and third stages together form the edge.
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      clr_s1_q <= 1'b0;
      clr_s2_q <= 1'b0;
      clr_s3_q <= 1'b0;
    end
    else
    begin
      clr_s1_q <= clr_tgl_q;
      clr_s2_q <= clr_s1_q;
      clr_s3_q <= clr_s2_q;
    end

  assign ready_clr = clr_s2_q ^ clr_s3_q;
  assign ready_set = !mod_rst_q && (init_cnt_q == INIT_CYC - 1);

  // Completion flag set one clock before pending clears, so attention rises with pending clear.
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      ready_q <= 1'b0;
    else if (mod_rst_q)
      ready_q <= 1'b0;
    else if (ready_set)
      ready_q <= 1'b1;
    else if (ready_clr)
      ready_q <= 1'b0;

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      att_q <= 1'b0;
    else
      att_q <= ready_q || (FAULT && !pend_q);

  assign LINK.att_o = 1'b0;
  assign LINK.att_oe = att_q;
  assign LINK.pres_o = 1'b0;
  assign LINK.pres_oe = 1'b1;

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      POWER_LOW <= 1'b1;
    else
      POWER_LOW <= pls_s2_q;

  assign INIT_PENDING = pend_q;

  // Status levels enter the link domain; they settle during the address bits.
  always_ff @(posedge LINK.scl or negedge link_rst_n_q)
    if (!link_rst_n_q)
    begin
      pend_l1_q <= 1'b1;
      pend_l2_q <= 1'b1;
      flt_l1_q  <= 1'b0;
      flt_l2_q  <= 1'b0;
      rdy_l1_q  <= 1'b0;
      rdy_l2_q  <= 1'b0;
    end
    else
    begin
      pend_l1_q <= pend_q;
      pend_l2_q <= pend_l1_q;
      flt_l1_q  <= FAULT;
      flt_l2_q  <= flt_l1_q;
      rdy_l1_q  <= ready_q;
      rdy_l2_q  <= rdy_l1_q;
    end

  assign addr_next = {addr_q[5:0], LINK.sda};

  always_comb
  begin
    rd_byte = 8'h00;
    case (addr_next)
      `PMC_DEV_STATUS:
      begin
        rd_byte[`PMC_ST_PEND]  = pend_l2_q;
        rd_byte[`PMC_ST_FAULT] = flt_l2_q;
        rd_byte[`PMC_ST_READY] = rdy_l2_q;
      end
      `PMC_DEV_LANES:
        rd_byte = {4'h0, lane_q};
      default:
        rd_byte = 8'h00;
    endcase
  end

  // The link clock stops between frames, so reset arrives asynchronously here.
  always_ff @(posedge LINK.scl or negedge link_rst_n_q)
    if (!link_rst_n_q)
    begin
      st_q   <= PMC_D_IDLE;
      cnt_q  <= 5'h00;
      rw_q   <= 1'b0;
      addr_q <= 7'h00;
      sh_q   <= 8'h00;
      oe_q   <= 1'b0;
    end
    else if (LINK.module_select_n)
    begin
      st_q  <= PMC_D_IDLE;
      cnt_q <= 5'h00;
      oe_q  <= 1'b0;
    end
    else
      case (st_q)
        PMC_D_IDLE:
          if (!LINK.sda)
          begin
            st_q  <= PMC_D_FRAME;
            cnt_q <= 5'h01;
          end
        PMC_D_FRAME:
        begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'h01)
            rw_q <= LINK.sda;
          else if (cnt_q <= `PMC_SLOT_ADDR)
          begin
            addr_q <= addr_next;
            if (cnt_q == `PMC_SLOT_ADDR && rw_q)
            begin
              oe_q <= !rd_byte[7];
              sh_q <= {rd_byte[6:0], 1'b0};
            end
          end
          else if (rw_q)
          begin
            oe_q <= !sh_q[7] && (cnt_q != `PMC_SLOT_LAST);
            sh_q <= {sh_q[6:0], 1'b0};
          end
          else
            sh_q <= {sh_q[6:0], LINK.sda};
          if (cnt_q == `PMC_SLOT_LAST)
          begin
            st_q  <= PMC_D_IDLE;
            cnt_q <= 5'h00;
            oe_q  <= 1'b0;
          end
        end
        default:
          st_q <= PMC_D_IDLE;
      endcase

  always_ff @(posedge LINK.scl or negedge link_rst_n_q)
    if (!link_rst_n_q)
      lane_q <= 4'h0;
    else if (!LINK.module_select_n && st_q == PMC_D_FRAME && !rw_q
             && cnt_q == `PMC_SLOT_LAST && addr_q == `PMC_DEV_LANES)
      lane_q <= {sh_q[2:0], LINK.sda};

  always_ff @(posedge LINK.scl or negedge link_rst_n_q)
    if (!link_rst_n_q)
      clr_tgl_q <= 1'b0;
    else if (!LINK.module_select_n && st_q == PMC_D_FRAME && rw_q
             && cnt_q == `PMC_SLOT_ADDR && addr_next == `PMC_DEV_STATUS)
      clr_tgl_q <= !clr_tgl_q;

  assign LANE_OFF = lane_q;
  assign LINK.sda_d_o = 1'b0;
  assign LINK.sda_d_oe = oe_q;
endmodule

// [pmc_chk_properties.sv]
// Concurrent checks on the low-speed pins between host controller and module.
module pmc_chk
#(
  parameter int unsigned INIT_CYC    = 50,
  parameter int unsigned RST_MIN_CYC = 4
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic module_select_n,
  input wire logic hard_restart_n,
  input wire logic sda_d_oe,
  input wire logic att_o,
  input wire logic att_oe,
  input wire logic attention_n,
  input wire logic presence_detect_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] init_cnt_q;
  logic [15:0] low_cnt_q;
  default clocking chk_cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // The count stops just past the init window, so it never wraps in long runs.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      init_cnt_q <= 32'h0000_0000;
    else if (init_cnt_q < INIT_CYC + 9)
      init_cnt_q <= init_cnt_q + 32'h0000_0001;
  end
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      low_cnt_q <= 16'h0000;
    else if (hard_restart_n)
      low_cnt_q <= 16'h0000;
    else if (low_cnt_q != 16'hFFFF)
      low_cnt_q <= low_cnt_q + 16'h0001;
  end
  sel_gate_a: assert property (module_select_n [*8] |-> !sda_d_oe)
    else $error("module drove data while deselected");
  att_drive_a: assert property (!att_o)
    else $error("attention driver level not low");
  att_wire_a: assert property (attention_n == !att_oe)
    else $error("attention wire does not follow its pull-down");
  pres_low_a: assert property (!presence_detect_n)
    else $error("presence line not low with module fitted");
  init_quiet_a: assert property (init_cnt_q < INIT_CYC |-> attention_n)
    else $error("attention raised before init time ran out");
  init_done_a: assert property (init_cnt_q == INIT_CYC + 8 |-> !attention_n)
    else $error("no completion attention after power-up");
  restart_clear_a: assert property (low_cnt_q == RST_MIN_CYC + 6 |-> attention_n)
    else $error("attention kept through a long restart");
  short_pulse_a: assert property
    (!hard_restart_n && low_cnt_q < RST_MIN_CYC && !attention_n |=> !attention_n)
    else $error("short restart pulse was not ignored");
  cover property (!sda_d_oe ##1 sda_d_oe);
  cover property (low_cnt_q == RST_MIN_CYC + 6);
  cover property ($rose(hard_restart_n) && low_cnt_q < RST_MIN_CYC);
endmodule

// [tb_pluggable_module_control_pins.sv]
// Self-checking bench joining host controller and module across the pin interface.
`include "pmc_map.svh"
module tb_pluggable_module_control_pins;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned INIT_CYC    = 50;
  localparam int unsigned RST_MIN_CYC = 4;
  logic        clk;
  logic        rst_n;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        fault;
  logic [3:0]  lane_off;
  logic        power_low;
  logic        init_pending;
  int          fails;
  int          n_compared;
  int          cycles;
  pmc_if link ();
  pmc_host pmc_host_i (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .LINK(link));
  pmc_device #(.INIT_CYC(INIT_CYC), .RST_MIN_CYC(RST_MIN_CYC)) pmc_device_i (.CLK(clk),
    .RST_N(rst_n), .LINK(link), .FAULT(fault), .LANE_OFF(lane_off), .POWER_LOW(power_low),
    .INIT_PENDING(init_pending));
  pmc_chk #(.INIT_CYC(INIT_CYC), .RST_MIN_CYC(RST_MIN_CYC)) pmc_chk_i (.CLK(clk),
    .RST_N(rst_n), .module_select_n(link.module_select_n),
    .hard_restart_n(link.hard_restart_n), .sda_d_oe(link.sda_d_oe), .att_o(link.att_o),
    .att_oe(link.att_oe), .attention_n(link.attention_n),
    .presence_detect_n(link.presence_detect_n));
  always #12.5 clk = !clk;
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Caps the run at 10000 clocks; a hung frame poll already gives up after 120 reads.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      fails = fails + 1;
      final_report();
    end
  end
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_init(output int t);
    t = 0;
    while (init_pending !== 1'b0 && t < 300)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    chk1("init wait", 1'b0, init_pending);
    idle(3);
  endtask
  task automatic frame(input logic [15:0] cmd, output logic [15:0] st);
    wr_reg(`PMC_HOST_TXN, cmd);
    st = 16'h0001;
    for (int i = 0; i < 120 && st[0] !== 1'b0; i++)
      rd_reg(`PMC_HOST_STATUS, st);
    chk1("frame done", 1'b0, st[0]);
  endtask
  task automatic test_power_up();
    logic [15:0] v;
    int          t;
    wait_init(t);
    chk1("init time", 1'b1, t >= INIT_CYC && t <= INIT_CYC + 8);
    chk1("attention", 1'b0, link.attention_n);
    chk1("presence", 1'b0, link.presence_detect_n);
    chk1("power low", 1'b1, power_low);
    chk16("lanes", 16'h0000, {12'h000, lane_off});
    rd_reg(`PMC_HOST_CTRL, v);
    chk16("ctrl", 16'h0004, v);
    rd_reg(2'h3, v);
    chk16("unmapped", 16'h0000, v);
    wr_reg(`PMC_HOST_CTRL, 16'h0005);
    frame(16'h0080, v);
    chk16("status", 16'h0404, v);
    chk1("attention", 1'b1, link.attention_n);
    $display("test power_up done");
  endtask
  task automatic test_lanes();
    logic [15:0] v;
    frame(16'hA501, v);
    idle(4);
    chk16("lanes", 16'h0005, {12'h000, lane_off});
    frame(16'h0081, v);
    chk16("lane read", 16'h0504, v);
    frame(16'h0085, v);
    chk16("empty read", 16'h0004, v);
    wr_reg(`PMC_HOST_CTRL, 16'h0004);
    frame(16'h0F01, v);
    idle(4);
    chk16("deselected write", 16'h0005, {12'h000, lane_off});
    frame(16'h0081, v);
    chk16("deselected read", 16'hFF04, v);
    $display("test lanes done");
  endtask
  task automatic test_power();
    wr_reg(`PMC_HOST_CTRL, 16'h0001);
    idle(5);
    chk1("power pin", 1'b0, link.power_limit_select);
    chk1("power low", 1'b0, power_low);
    wr_reg(`PMC_HOST_CTRL, 16'h0005);
    idle(5);
    chk1("power low", 1'b1, power_low);
    $display("test power done");
  endtask
  task automatic test_fault_restart();
    logic [15:0] v;
    int          t;
    @(posedge clk);
    fault <= 1'b1;
    idle(4);
    chk1("fault attention", 1'b0, link.attention_n);
    frame(16'h0080, v);
    chk16("fault status", 16'h0206, v);
    wr_reg(`PMC_HOST_CTRL, 16'h0007);
    wr_reg(`PMC_HOST_CTRL, 16'h0005);
    idle(8);
    chk1("short pulse", 1'b0, init_pending);
    wr_reg(`PMC_HOST_CTRL, 16'h0007);
    idle(RST_MIN_CYC + 10);
    chk1("restart pending", 1'b1, init_pending);
    chk1("masked fault", 1'b1, link.attention_n);
    chk16("lane default", 16'h0000, {12'h000, lane_off});
    wr_reg(`PMC_HOST_CTRL, 16'h0005);
    @(posedge clk);
    fault <= 1'b0;
    wait_init(t);
    chk1("restart done", 1'b0, link.attention_n);
    frame(16'h0080, v);
    chk16("restart status", 16'h0404, v);
    $display("test fault_restart done");
  endtask
  initial
  begin
    clk        = 1'b0;
    rst_n      = 1'b0;
    addr       = 2'h0;
    wdata      = 16'h0000;
    wr         = 1'b0;
    rd         = 1'b0;
    fault      = 1'b0;
    fails      = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    test_power_up();
    test_lanes();
    test_power();
    test_fault_restart();
    final_report();
  end
endmodule
